// >>> crs_cfg.svh
/*
 * constants of the register and stack unit: bus offsets, flag positions,
 * memory map bounds, vectors and command codes.
 * assumes inclusion by bare name from core and bench.
 */
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

`define CRS_OFF_ACC 6'h00
`define CRS_OFF_X 6'h04
`define CRS_OFF_Y 6'h08
`define CRS_OFF_SP 6'h0c
`define CRS_OFF_PC 6'h10
`define CRS_OFF_ST 6'h14
`define CRS_OFF_CMD 6'h18
`define CRS_OFF_PROBE 6'h1c

`define CRS_F_C 0
`define CRS_F_Z 1
`define CRS_F_I 2
`define CRS_F_D 3
`define CRS_F_B 4
`define CRS_F_T 5
`define CRS_F_V 6
`define CRS_F_N 7
`define CRS_ST_RESET 8'h04

`define CRS_ROM_LO 16'h2800
`define CRS_ROM_HI 16'h3fff
`define CRS_SPC_LO 16'h3f00
`define CRS_SPC_PAGE 6'h3f
`define CRS_VEC_LO 16'h3ff4
`define CRS_ZP_HI 16'h00ff
`define CRS_RAM_HI 16'h00bf
`define CRS_RAM_DEPTH 192
`define CRS_VEC_RESET 16'h3ffe
`define CRS_VEC_BRK 16'h3ff4
`define CRS_LVL_MIN 3'h2
`define CRS_LVL_MAX 3'h6

`define CRS_CMD_OP 4:0
`define CRS_CMD_LO 15:8
`define CRS_CMD_HI 21:16
`define CRS_CMD_LVL 26:24

`define CRS_OP_SET_C 5'h01
`define CRS_OP_CLR_C 5'h02
`define CRS_OP_SET_I 5'h03
`define CRS_OP_CLR_I 5'h04
`define CRS_OP_SET_D 5'h05
`define CRS_OP_CLR_D 5'h06
`define CRS_OP_CLV 5'h07
`define CRS_OP_SETT 5'h08
`define CRS_OP_CLR_T 5'h09
`define CRS_OP_SP_FROM_X 5'h0a
`define CRS_OP_PUSH_A 5'h0b
`define CRS_OP_PULL_A 5'h0c
`define CRS_OP_PUSH_ST 5'h0d
`define CRS_OP_PULL_ST 5'h0e
`define CRS_OP_CALL 5'h0f
`define CRS_OP_CALL_SPC 5'h10
`define CRS_OP_RTS 5'h11
`define CRS_OP_BREAK 5'h12
`define CRS_OP_IRQ 5'h13
`define CRS_OP_RET_IRQ 5'h14
`define CRS_OP_LDAX 5'h15
`define CRS_OP_LDAY 5'h16
`define CRS_OP_STAX 5'h17
`define CRS_OP_ADC 5'h18
`define CRS_OP_SBC 5'h19
`define CRS_OP_BIT 5'h1a
`define CRS_OP_ROL 5'h1b

`endif

// >>> crs_pkg.sv
/*
 * types of the register and stack unit.
 * assumes crs_cfg.svh for all numeric constants.
 */
package crs_pkg;
    typedef enum logic [2:0] {st_idle, st_push_pcl, st_push_ps, st_pop_pcl, st_pop_pch} crs_state_type;
    typedef enum logic [1:0] {ent_call, ent_break, ent_irq} crs_entry_type;
endpackage

// >>> crs_core.sv
/*
 * programmer-visible registers, stack engine and memory map decoder of an
 * 8-bit core, reached over an avalon-mm slave with waitrequest.
 * assumes one 50 mhz clock, synchronous active-low reset and a master that
 * holds its request until waitrequest is sampled low.
 */
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "crs_cfg.svh"
module crs_core (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    logic [7:0] ram [0:`CRS_RAM_DEPTH-1];
    logic [7:0] acc, idx_x, idx_y, stack_ptr, pc_low, stat;
    logic [5:0] pc_high;
    logic [15:0] probe_addr, call_target;
    logic [31:0] last_cmd;
    crs_pkg::crs_state_type state;
    crs_pkg::crs_entry_type entry;
    logic [7:0] next_acc, next_x, next_y, next_sp, next_pcl, next_stat;
    logic [5:0] next_pch;
    logic [15:0] next_target;
    crs_pkg::crs_state_type next_state;
    crs_pkg::crs_entry_type next_entry;
    logic ram_we;
    logic [7:0] ram_wa, ram_wd;

    function automatic logic [7:0] ram_rd(input logic [7:0] a);
        ram_rd = ({8'h00, a} <= `CRS_RAM_HI) ? ram[a] : 8'h00;
    endfunction

    function automatic logic [7:0] with_nz(input logic [7:0] p, input logic [7:0] v);
        with_nz = p;
        with_nz[`CRS_F_N] = v[7];
        with_nz[`CRS_F_Z] = (v == 8'h00);
    endfunction

    // bus decode; everything stalls while a stack sequence runs
    wire bus_busy = (state != crs_pkg::st_idle);
    wire bus_req = avs_read | avs_write;
    wire bus_wr = avs_write & ~avs_waitrequest;
    wire lane0 = bus_wr & avs_byteenable[0];
    wire lane1 = bus_wr & avs_byteenable[1];
    wire sel_acc = (avs_address == `CRS_OFF_ACC);
    wire sel_x = (avs_address == `CRS_OFF_X);
    wire sel_y = (avs_address == `CRS_OFF_Y);
    wire sel_sp = (avs_address == `CRS_OFF_SP);
    wire sel_pc = (avs_address == `CRS_OFF_PC);
    wire sel_stat = (avs_address == `CRS_OFF_ST);
    wire sel_cmd = (avs_address == `CRS_OFF_CMD);
    wire sel_probe = (avs_address == `CRS_OFF_PROBE);
    wire cmd_go = lane0 & sel_cmd;
    wire [4:0] op = avs_writedata[`CRS_CMD_OP];
    wire [7:0] opnd = avs_writedata[`CRS_CMD_LO];
    wire [5:0] opnd_hi = avs_writedata[`CRS_CMD_HI];
    wire [2:0] irq_lvl = avs_writedata[`CRS_CMD_LVL];

    // memory map decode of the probe address
    wire region_ram = (probe_addr <= `CRS_RAM_HI);
    wire region_zp = (probe_addr <= `CRS_ZP_HI);
    wire region_rom = (probe_addr >= `CRS_ROM_LO) && (probe_addr <= `CRS_ROM_HI);
    wire region_spc = (probe_addr >= `CRS_SPC_LO) && (probe_addr <= `CRS_ROM_HI);
    wire region_vec = (probe_addr >= `CRS_VEC_LO) && (probe_addr <= `CRS_ROM_HI);

    // effective addresses wrap inside page zero
    wire [7:0] ea_x = opnd + idx_x;
    wire [7:0] ea_y = opnd + idx_y;
    wire [7:0] sp_up = stack_ptr + 8'h01;
    wire [7:0] sp_dn = stack_ptr - 8'h01;
    wire [7:0] pop_val = ram_rd(sp_up);
    wire [2:0] lvl_m1 = irq_lvl - 3'h1;
    wire [15:0] irq_vec = `CRS_VEC_RESET - {12'h000, lvl_m1, 1'b0};
    wire irq_ok = ~stat[`CRS_F_I] && (irq_lvl >= `CRS_LVL_MIN) && (irq_lvl <= `CRS_LVL_MAX);

    // alu: with t set the first operand is memory at x, not the accumulator
    wire [7:0] alu_a = stat[`CRS_F_T] ? ram_rd(idx_x) : acc;
    wire [7:0] alu_m = ram_rd(opnd);
    wire cin = stat[`CRS_F_C];
    wire [8:0] bin_sum = {1'b0, alu_a} + {1'b0, alu_m} + {8'h00, cin};
    wire [8:0] bin_dif = {1'b0, alu_a} - {1'b0, alu_m} - {8'h00, ~cin};
    wire [4:0] dlo_s = {1'b0, alu_a[3:0]} + {1'b0, alu_m[3:0]} + {4'h0, cin};
    wire [4:0] dlo_a = (dlo_s > 5'h09) ? dlo_s + 5'h06 : dlo_s;
    wire [4:0] dhi_s = {1'b0, alu_a[7:4]} + {1'b0, alu_m[7:4]} + {4'h0, dlo_a[4]};
    wire [4:0] dhi_a = (dhi_s > 5'h09) ? dhi_s + 5'h06 : dhi_s;
    wire [4:0] dlo_d = {1'b0, alu_a[3:0]} - {1'b0, alu_m[3:0]} - {4'h0, ~cin};
    wire [4:0] dlo_c = dlo_d[4] ? dlo_d - 5'h06 : dlo_d;
    wire [4:0] dhi_d = {1'b0, alu_a[7:4]} - {1'b0, alu_m[7:4]} - {4'h0, dlo_d[4]};
    wire [4:0] dhi_c = dhi_d[4] ? dhi_d - 5'h06 : dhi_d;
    wire is_sub = (op == `CRS_OP_SBC);
    wire dec = stat[`CRS_F_D];
    // decimal correction only when the decimal flag is set
    wire [7:0] alu_r = is_sub ? (dec ? {dhi_c[3:0], dlo_c[3:0]} : bin_dif[7:0])
                              : (dec ? {dhi_a[3:0], dlo_a[3:0]} : bin_sum[7:0]);
    wire alu_c = is_sub ? ~(dec ? dhi_d[4] : bin_dif[8]) : (dec ? dhi_a[4] : bin_sum[8]);
    // signed overflow judged on the binary result in both modes
    wire alu_v = is_sub ? ((alu_a[7] != alu_m[7]) && (bin_dif[7] != alu_a[7]))
                        : ((alu_a[7] == alu_m[7]) && (bin_sum[7] != alu_a[7]));

    always_comb begin
        next_acc = acc;
        next_x = idx_x;
        next_y = idx_y;
        next_sp = stack_ptr;
        next_pcl = pc_low;
        next_pch = pc_high;
        next_stat = stat;
        next_target = call_target;
        next_state = state;
        next_entry = entry;
        ram_we = 1'b0;
        ram_wa = stack_ptr;
        ram_wd = 8'h00;
        case (state)
            crs_pkg::st_idle: begin
                if (lane0 && sel_acc) next_acc = avs_writedata[7:0];
                if (lane0 && sel_x) next_x = avs_writedata[7:0];
                if (lane0 && sel_y) next_y = avs_writedata[7:0];
                if (lane0 && sel_sp) next_sp = avs_writedata[7:0];
                if (lane0 && sel_pc) next_pcl = avs_writedata[7:0];
                if (lane1 && sel_pc) next_pch = avs_writedata[13:8];
                if (lane0 && sel_stat) next_stat = avs_writedata[7:0];
                if (cmd_go) begin
                    case (op)
                        `CRS_OP_SET_C: next_stat[`CRS_F_C] = 1'b1;
                        `CRS_OP_CLR_C: next_stat[`CRS_F_C] = 1'b0;
                        `CRS_OP_SET_I: next_stat[`CRS_F_I] = 1'b1;
                        `CRS_OP_CLR_I: next_stat[`CRS_F_I] = 1'b0;
                        `CRS_OP_SET_D: next_stat[`CRS_F_D] = 1'b1;
                        `CRS_OP_CLR_D: next_stat[`CRS_F_D] = 1'b0;
                        `CRS_OP_CLV: next_stat[`CRS_F_V] = 1'b0;
                        `CRS_OP_SETT: next_stat[`CRS_F_T] = 1'b1;
                        `CRS_OP_CLR_T: next_stat[`CRS_F_T] = 1'b0;
                        `CRS_OP_SP_FROM_X: next_sp = idx_x;
                        `CRS_OP_PUSH_A, `CRS_OP_PUSH_ST: begin
                            ram_we = 1'b1;
                            ram_wd = (op == `CRS_OP_PUSH_A) ? acc : stat;
                            next_sp = sp_dn;
                        end
                        `CRS_OP_PULL_A: begin
                            next_sp = sp_up;
                            next_acc = pop_val;
                            next_stat = with_nz(stat, pop_val);
                        end
                        `CRS_OP_PULL_ST: begin
                            next_sp = sp_up;
                            next_stat = pop_val;
                        end
                        `CRS_OP_CALL, `CRS_OP_CALL_SPC, `CRS_OP_BREAK: begin
                            ram_we = 1'b1;
                            ram_wd = {2'h0, pc_high};
                            next_sp = sp_dn;
                            next_state = crs_pkg::st_push_pcl;
                            next_entry = (op == `CRS_OP_BREAK) ? crs_pkg::ent_break : crs_pkg::ent_call;
                            if (op == `CRS_OP_CALL) next_target = {2'h0, opnd_hi, opnd};
                            else if (op == `CRS_OP_CALL_SPC) next_target = {2'h0, `CRS_SPC_PAGE, opnd};
                            else next_target = `CRS_VEC_BRK;
                        end
                        `CRS_OP_IRQ: begin
                            if (irq_ok) begin
                                ram_we = 1'b1;
                                ram_wd = {2'h0, pc_high};
                                next_sp = sp_dn;
                                next_state = crs_pkg::st_push_pcl;
                                next_entry = crs_pkg::ent_irq;
                                next_target = irq_vec;
                            end
                        end
                        `CRS_OP_RET_IRQ: begin
                            next_sp = sp_up;
                            next_stat = pop_val;
                            next_state = crs_pkg::st_pop_pcl;
                        end
                        `CRS_OP_RTS: begin
                            next_sp = sp_up;
                            next_pcl = pop_val;
                            next_state = crs_pkg::st_pop_pch;
                        end
                        `CRS_OP_LDAX, `CRS_OP_LDAY: begin
                            next_acc = ram_rd((op == `CRS_OP_LDAX) ? ea_x : ea_y);
                            next_stat = with_nz(stat, next_acc);
                        end
                        `CRS_OP_STAX: begin
                            ram_we = 1'b1;
                            ram_wa = ea_x;
                            ram_wd = acc;
                        end
                        `CRS_OP_ADC, `CRS_OP_SBC: begin
                            if (stat[`CRS_F_T]) begin
                                ram_we = 1'b1;
                                ram_wa = idx_x;
                                ram_wd = alu_r;
                            end else begin
                                next_acc = alu_r;
                            end
                            next_stat = with_nz(stat, alu_r);
                            next_stat[`CRS_F_C] = alu_c;
                            next_stat[`CRS_F_V] = alu_v;
                        end
                        `CRS_OP_BIT: begin
                            next_stat[`CRS_F_N] = alu_m[7];
                            next_stat[`CRS_F_V] = alu_m[6];
                            next_stat[`CRS_F_Z] = ((acc & alu_m) == 8'h00);
                        end
                        `CRS_OP_ROL: begin
                            next_acc = {acc[6:0], cin};
                            next_stat = with_nz(stat, next_acc);
                            next_stat[`CRS_F_C] = acc[7];
                        end
                        default: next_state = crs_pkg::st_idle;
                    endcase
                end
            end
            crs_pkg::st_push_pcl: begin
                ram_we = 1'b1;
                ram_wd = pc_low;
                next_sp = sp_dn;
                if (entry == crs_pkg::ent_call) begin
                    next_pcl = call_target[7:0];
                    next_pch = call_target[13:8];
                    next_state = crs_pkg::st_idle;
                end else begin
                    next_state = crs_pkg::st_push_ps;
                end
            end
            crs_pkg::st_push_ps: begin
                ram_we = 1'b1;
                ram_wd = stat;
                ram_wd[`CRS_F_B] = (entry == crs_pkg::ent_break);
                next_sp = sp_dn;
                next_stat[`CRS_F_I] = 1'b1;
                next_pcl = call_target[7:0];
                next_pch = call_target[13:8];
                next_state = crs_pkg::st_idle;
            end
            crs_pkg::st_pop_pcl: begin
                next_sp = sp_up;
                next_pcl = pop_val;
                next_state = crs_pkg::st_pop_pch;
            end
            crs_pkg::st_pop_pch: begin
                next_sp = sp_up;
                next_pch = pop_val[5:0];
                next_state = crs_pkg::st_idle;
            end
            default: next_state = crs_pkg::st_idle;
        endcase
    end

    wire [31:0] rd_word = sel_acc ? {24'h000000, acc} :
                          sel_x ? {24'h000000, idx_x} :
                          sel_y ? {24'h000000, idx_y} :
                          sel_sp ? {24'h000000, stack_ptr} :
                          sel_pc ? {16'h0000, 2'h0, pc_high, pc_low} :
                          sel_stat ? {24'h000000, stat} :
                          sel_cmd ? last_cmd :
                          sel_probe ? {probe_addr, 11'h000, region_vec, region_spc, region_rom, region_zp, region_ram} :
                          32'h00000000;

    // at least one wait cycle per access keeps readdata and waitrequest registered
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (bus_req && !bus_busy) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_word : 32'h00000000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            acc <= 8'h00;
            idx_x <= 8'h00;
            idx_y <= 8'h00;
            pc_low <= 8'(`CRS_VEC_RESET);
            pc_high <= 6'(`CRS_VEC_RESET >> 8);
            stat <= `CRS_ST_RESET;
            call_target <= 16'h0000;
            state <= crs_pkg::st_idle;
            entry <= crs_pkg::ent_call;
            probe_addr <= 16'h0000;
            last_cmd <= 32'h00000000;
        end else begin
            acc <= next_acc;
            idx_x <= next_x;
            idx_y <= next_y;
            pc_low <= next_pcl;
            pc_high <= next_pch;
            stat <= next_stat;
            call_target <= next_target;
            state <= next_state;
            entry <= next_entry;
            if (lane0 && sel_probe) probe_addr <= avs_writedata[15:0];
            if (cmd_go) last_cmd <= avs_writedata;
        end
    end

    // stack pointer is left out of reset on purpose; software must load it
    always_ff @(posedge core_clk) begin
        stack_ptr <= nrst ? next_sp : stack_ptr;
        if (ram_we && ({8'h00, ram_wa} <= `CRS_RAM_HI)) ram[ram_wa] <= ram_wd;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    wire entry_go = (state == crs_pkg::st_idle) && (next_state == crs_pkg::st_push_pcl);
    sequence push_three;
        (state == crs_pkg::st_push_pcl) ##1 (state == crs_pkg::st_push_ps) ##1 (state == crs_pkg::st_idle);
    endsequence
    sequence pop_three;
        (state == crs_pkg::st_pop_pcl) ##1 (state == crs_pkg::st_pop_pch) ##1 (state == crs_pkg::st_idle);
    endsequence

    chk_rom_bounds: assert property (region_rom |-> !region_zp && (probe_addr[15:14] == 2'h0))
        else $error("rom region outside 2800-3fff");
    chk_special_call: assert property ((cmd_go && op == `CRS_OP_CALL_SPC) |-> ##2 (pc_high == 6'h3f))
        else $error("short call did not land in special page");
    chk_vector_page: assert property (region_vec |-> region_spc && region_rom)
        else $error("vector area outside special page");
    chk_ram_zero_page: assert property (region_ram |-> region_zp && !region_rom)
        else $error("ram not inside zero page");
    chk_irq_push_order: assert property ((entry_go && next_entry != crs_pkg::ent_call) |=> push_three)
        else $error("interrupt push sequence broken");
    chk_irq_sp_walk: assert property ((entry_go && next_entry != crs_pkg::ent_call) |-> ##3
        (stack_ptr == $past(stack_ptr, 3) - 8'h03))
        else $error("entry did not lower stack pointer by three");
    chk_rti_pop_order: assert property ((cmd_go && op == `CRS_OP_RET_IRQ) |=> pop_three)
        else $error("return from interrupt pop sequence broken");
    chk_call_pc_only: assert property ((entry_go && next_entry == crs_pkg::ent_call) |=>
        (state == crs_pkg::st_push_pcl) ##1 (state == crs_pkg::st_idle))
        else $error("call pushed more than the pc");
    chk_entry_masks: assert property ((state == crs_pkg::st_push_ps) |=> stat[`CRS_F_I])
        else $error("interrupt disable not set on entry");
    chk_break_flag: assert property ((state == crs_pkg::st_push_ps) |->
        (ram_wd[`CRS_F_B] == (entry == crs_pkg::ent_break)))
        else $error("pushed break flag wrong");
    chk_zero_flag: assert property ((cmd_go && op == `CRS_OP_LDAX) |=> (stat[`CRS_F_Z] == (acc == 8'h00)))
        else $error("zero flag polarity wrong");
endmodule

// >>> crs_host.sv
/* avalon-mm host model that drives the register unit.
   assumes core_clk and a slave answering with waitrequest low. */
`timescale 1ns/1ps
module crs_host (
    input wire logic clk,
    input wire logic wait_req,
    output logic [5:0] adr,
    output logic rd_en,
    output logic wr_en,
    output logic [31:0] wdat
);
    initial begin
        adr = 6'h00;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdat = 32'h0;
    end
    // request held until waitrequest is sampled low, bounded wait
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        rd_en <= !w;
        wr_en <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        if (wait_req !== 1'b0) tb_top.hang();
    endtask
endmodule

// >>> tb_top.sv
/* self-checking bench of the register and stack unit.
   assumes crs_core, crs_host and crs_cfg.svh. */
`timescale 1ns/1ps
`include "crs_cfg.svh"
module tb_top;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, v, nzv;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'd55069;
    int n_errors = 0;
    int cmp_count = 0;
    logic [4:0] fo[8] = '{`CRS_OP_SET_C, `CRS_OP_CLR_I, `CRS_OP_SET_D, `CRS_OP_SETT,
        `CRS_OP_CLR_C, `CRS_OP_SET_I, `CRS_OP_CLR_D, `CRS_OP_CLR_T};
    logic [7:0] fp[8] = '{8'h05, 8'h01, 8'h09, 8'h29, 8'h28, 8'h2c, 8'h24, 8'h04};
    logic [15:0] pa[8] = '{16'h27ff, 16'h2800, 16'h3f00, 16'h3ff3, 16'h3ff4, 16'h00bf, 16'h00c0, 16'h0100};
    logic [4:0] pf[8] = '{5'h00, 5'h04, 5'h0c, 5'h0c, 5'h1c, 5'h03, 5'h02, 5'h00};
    logic [7:0] aa[3] = '{8'hb0, 8'h50, 8'h19};
    logic [7:0] am[3] = '{8'h50, 8'h50, 8'h01};
    logic [7:0] ae[3] = '{8'h00, 8'ha0, 8'h20};
    logic [7:0] ap[3] = '{8'h03, 8'hc0, 8'h08};
    always #10 core_clk = ~core_clk;
    crs_core dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    crs_host host (.clk(core_clk), .wait_req(avs_waitrequest), .adr(avs_address), .rd_en(avs_read),
        .wr_en(avs_write), .wdat(avs_writedata));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR at %0t: read %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic hang();
        n_errors++;
        give_verdict();
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [4:0] op, input logic [7:0] lo, input logic [2:0] lv);
        wr(`CRS_OFF_CMD, {5'h0, lv, 8'h0, lo, 3'h0, op});
    endtask
    // oldest note is matched against each completed read
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) check(avs_readdata, exp_q.pop_front());
    end
    initial begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`CRS_OFF_ST, 32'h04);
        rd(`CRS_OFF_PC, 32'h3ffe);
        for (int i = 0; i < 3; i++) begin
            v = rnd() & 32'hff;
            wr(6'(i * 4), v);
            rd(6'(i * 4), v);
        end
        wr(`CRS_OFF_PC, 32'hffff);
        rd(`CRS_OFF_PC, 32'h3fff);
        rd(6'h20, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            cmd(fo[i], 8'h0, 3'h0);
            rd(`CRS_OFF_ST, {24'h0, fp[i]});
            wr(`CRS_OFF_PROBE, {16'h0, pa[i]});
            rd(`CRS_OFF_PROBE, {pa[i], 11'h0, pf[i]});
        end
        $display("test flags and map done");
        wr(`CRS_OFF_SP, 32'h80);
        wr(`CRS_OFF_X, 32'h0);
        v = rnd() & 32'hff;
        // pulled value leaves its sign and zero marks in status
        nzv = {24'h0, v[7], 5'h0, v[7:0] == 8'h00, 1'b0};
        wr(`CRS_OFF_ACC, v);
        cmd(`CRS_OP_PUSH_A, 8'h0, 3'h0);
        wr(`CRS_OFF_ACC, 32'h0);
        rd(`CRS_OFF_SP, 32'h7f);
        cmd(`CRS_OP_LDAX, 8'h80, 3'h0);
        rd(`CRS_OFF_ACC, v);
        wr(`CRS_OFF_ACC, 32'h0);
        cmd(`CRS_OP_PULL_A, 8'h0, 3'h0);
        rd(`CRS_OFF_ACC, v);
        cmd(`CRS_OP_SET_C, 8'h0, 3'h0);
        cmd(`CRS_OP_PUSH_ST, 8'h0, 3'h0);
        cmd(`CRS_OP_CLR_C, 8'h0, 3'h0);
        cmd(`CRS_OP_PULL_ST, 8'h0, 3'h0);
        rd(`CRS_OFF_ST, 32'h05 | nzv);
        wr(`CRS_OFF_PC, 32'h2abc);
        cmd(`CRS_OP_CALL_SPC, 8'h34, 3'h0);
        rd(`CRS_OFF_PC, 32'h3f34);
        rd(`CRS_OFF_SP, 32'h7e);
        cmd(`CRS_OP_RTS, 8'h0, 3'h0);
        rd(`CRS_OFF_PC, 32'h2abc);
        $display("test stack done");
        for (int k = 0; k < 2; k++) begin
            cmd(`CRS_OP_CLR_I, 8'h0, 3'h0);
            cmd(k ? `CRS_OP_IRQ : `CRS_OP_BREAK, 8'h0, 3'h3);
            cmd(`CRS_OP_IRQ, 8'h0, 3'h2);
            rd(`CRS_OFF_PC, k ? 32'h3ffa : 32'h3ff4);
            rd(`CRS_OFF_SP, 32'h7d);
            for (int j = 0; j < 3; j++) begin
                cmd(`CRS_OP_LDAX, 8'(8'h80 - j), 3'h0);
                rd(`CRS_OFF_ACC, j == 0 ? 32'h2a : j == 1 ? 32'hbc : (k ? 32'h01 : 32'h11) | nzv);
            end
            cmd(`CRS_OP_RET_IRQ, 8'h0, 3'h0);
            rd(`CRS_OFF_ST, (k ? 32'h01 : 32'h11) | nzv);
            rd(`CRS_OFF_PC, 32'h2abc);
        end
        $display("test interrupt entry done");
        for (int i = 0; i < 3; i++) begin
            wr(`CRS_OFF_ACC, {24'h0, am[i]});
            cmd(`CRS_OP_STAX, 8'h10, 3'h0);
            wr(`CRS_OFF_ACC, {24'h0, aa[i]});
            cmd(`CRS_OP_CLR_C, 8'h0, 3'h0);
            cmd(i == 2 ? `CRS_OP_SET_D : `CRS_OP_CLR_D, 8'h0, 3'h0);
            cmd(`CRS_OP_ADC, 8'h10, 3'h0);
            rd(`CRS_OFF_ACC, {24'h0, ae[i]});
            rd(`CRS_OFF_ST, {24'h0, ap[i]});
        end
        $display("test arithmetic done");
        repeat (2) @(posedge core_clk);
        give_verdict();
    end
endmodule
